/* File: hw/ubs_brg.sv */
// Baud source: power-of-two prescaler or synchronised external clock pin
`timescale 1ns/1ps
`default_nettype none
`include "ubs_params.svh"
module ubs_brg
   import ubs_pkg::*;
(
   input  wire logic       sys_clk,  // System clock
   input  wire logic       srst,     // Synchronous reset
   input  wire logic       clk_en,   // Freezes all state while low
   input  wire logic [3:0] sel,      // Source select code
   input  wire logic       ext_pin,  // External baud clock pin
   output logic            os_tick   // One pulse per source clock period
);
   logic [7:0] pre;
   logic [7:0] mask;
   logic       ext_meta;
   logic       ext_sync;
   logic       ext_dly;

   // Code k divides by 2^(k+1): low k+1 prescaler bits all ones
   always_comb mask = 8'hFF >> (3'h7 - sel[2:0]);

   // Free running prescaler
   always_ff @(posedge sys_clk) begin
      if (srst) pre <= 8'h00;
      else if (clk_en) pre <= pre + 8'h01;
   end

   // Pin synchroniser; the second stage and its delayed copy (ext_dly) feed the edge detector
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_dly  <= 1'b0;
      end else if (clk_en) begin
         ext_meta <= ext_pin;
         ext_sync <= ext_meta;
         ext_dly  <= ext_sync;
      end
   end

   // Prohibited codes give no tick at all, so the link simply stalls
   always_ff @(posedge sys_clk) begin
      if (srst) os_tick <= 1'b0;
      else if (clk_en) begin
         if (sel[3]) os_tick <= (sel == `UBS_SEL_EXT) && ext_sync && !ext_dly;
         else os_tick <= ((pre & mask) == mask);
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   // Leading cycle makes sure the first tick already came from code 1, not the old code
   property p_div4;
      (clk_en && sel == 4'h1) ##1 (os_tick && clk_en && sel == 4'h1)
         ##1 (clk_en && sel == 4'h1) [*3] |=> os_tick;
   endproperty
   a_div4: assert property (p_div4) else $error("divide by four period wrong");

   property p_prohibited;
      sel[3] && sel != `UBS_SEL_EXT ##1 sel[3] && sel != `UBS_SEL_EXT |-> !os_tick;
   endproperty
   a_prohibited: assert property (p_prohibited) else $error("tick on prohibited code");
endmodule : ubs_brg
`default_nettype wire

/* File: hw/ubs_params.svh */
// Register map, field positions, reset values and timing counts of the serial block
`ifndef UBS_PARAMS_SVH
`define UBS_PARAMS_SVH
// Register offsets
`define UBS_ADDR_MODE  16'hFF70
`define UBS_ADDR_STAT  16'hFF71
`define UBS_ADDR_BAUD  16'hFF73
`define UBS_ADDR_RXB   16'hFF74
`define UBS_ADDR_TXB   16'hFF75
`define UBS_ADDR_STATE 16'hFF76
// Reset values
`define UBS_MODE_RST   8'h00
`define UBS_BAUD_RST   4'h0
`define UBS_RXB_RST    8'h00
// Status field positions
`define UBS_PE_BIT     2
`define UBS_FE_BIT     1
`define UBS_OVE_BIT    0
// Baud select field and codes
`define UBS_SEL_LSB    4
`define UBS_SEL_EXT    4'h8
// Oversample counts: sixteen source ticks per bit, sample in the middle
`define UBS_OS_LAST    4'hF
`define UBS_OS_MID     4'h7
`endif

/* File: hw/ubs_pkg.sv */
// Types shared by the serial block: mode fields, error flags and state encodings
package ubs_pkg;
   typedef enum logic [1:0] {
      UBS_PAR_NONE = 2'h0,
      UBS_PAR_ZERO = 2'h1,
      UBS_PAR_ODD  = 2'h2,
      UBS_PAR_EVEN = 2'h3
   } ubs_par_t;

   typedef struct packed {
      logic       tx_en;
      logic       rx_en;
      ubs_par_t   parity_sel;
      logic       char_length_bit;
      logic       stop_length_bit;
      logic [1:0] rsvd;
   } ubs_mode_t;

   typedef struct packed {
      logic parity_error_flag;
      logic framing_error_flag;
      logic overrun_flag;
   } ubs_err_t;

   typedef enum logic [4:0] {
      UBS_RX_IDLE  = 5'h01,
      UBS_RX_START = 5'h02,
      UBS_RX_DATA  = 5'h04,
      UBS_RX_PAR   = 5'h08,
      UBS_RX_STOP  = 5'h10
   } ubs_rx_st_t;

   typedef enum logic [4:0] {
      UBS_TX_IDLE  = 5'h01,
      UBS_TX_START = 5'h02,
      UBS_TX_DATA  = 5'h04,
      UBS_TX_PAR   = 5'h08,
      UBS_TX_STOP  = 5'h10
   } ubs_tx_st_t;

   // Odd count of ones among the valid character bits
   function automatic logic ubs_ones_odd(input logic [7:0] d, input logic char8);
      return ^(char8 ? d : {1'b0, d[6:0]});
   endfunction : ubs_ones_odd
endpackage : ubs_pkg

/* File: hw/ubs_top.sv */
// Asynchronous serial block: mode, error status, baud select, receiver and transmitter
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ubs_params.svh"
module ubs_top
   import ubs_pkg::*;
(
   input  wire logic        sys_clk,                  // System clock, 40 MHz
   input  wire logic        srst,                     // Synchronous reset, active high
   input  wire logic        clk_en,                   // Freezes all state while low
   input  wire logic [15:0] addr,                     // Register address
   input  wire logic [7:0]  wr_data,                  // Write data
   input  wire logic        wr_stb,                   // Write strobe, one cycle
   input  wire logic        rd_stb,                   // Read strobe, one cycle
   output logic      [7:0]  rd_data,                  // Read data, cycle after strobe
   input  wire logic        rxd_pin,                  // Serial receive pin
   input  wire logic        external_baud_clock_pin,  // External baud source pin
   output logic             txd                       // Serial transmit pin, idles high
);
   ubs_mode_t  async_mode_reg;
   logic [3:0] baud_sel;
   ubs_err_t   err;
   ubs_err_t   done_err;
   logic [7:0] receive_buffer;
   logic       rx_full;
   logic       os_tick;
   logic       rx_meta;
   logic       rx_sync;
   ubs_rx_st_t rx_st;
   logic [3:0] rx_os;
   logic [2:0] rx_idx;
   logic [7:0] rx_shift;
   logic       rx_par;
   logic       frame_done;
   logic       rxb_read;
   ubs_tx_st_t tx_st;
   logic [3:0] tx_os;
   logic [2:0] tx_idx;
   logic [2:0] next_tx_idx;
   logic [2:0] last_idx;
   logic [7:0] tx_char;
   logic       tx_stop2nd;
   logic       tx_go;
   logic       par_bit;
   logic [7:0] stat_byte;

   ubs_brg u_brg (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .sel     (baud_sel),
      .ext_pin (external_baud_clock_pin),
      .os_tick (os_tick)
   );

   // Strobe decodes and shared helpers
   assign rxb_read    = clk_en && rd_stb && (addr == `UBS_ADDR_RXB);
   assign tx_go       = clk_en && wr_stb && (addr == `UBS_ADDR_TXB)
                        && async_mode_reg.tx_en && (tx_st == UBS_TX_IDLE);
   assign last_idx    = async_mode_reg.char_length_bit ? 3'h7 : 3'h6;
   assign next_tx_idx = tx_idx + 3'h1;

   // Mode register; low two bits stay zero
   always_ff @(posedge sys_clk) begin
      if (srst) async_mode_reg <= ubs_mode_t'(`UBS_MODE_RST);
      else if (clk_en && wr_stb && addr == `UBS_ADDR_MODE)
         async_mode_reg <= ubs_mode_t'({wr_data[7:2], 2'b00});
   end

   // Baud select; only the upper nibble is stored
   always_ff @(posedge sys_clk) begin
      if (srst) baud_sel <= `UBS_BAUD_RST;
      else if (clk_en && wr_stb && addr == `UBS_ADDR_BAUD)
         baud_sel <= wr_data[7:4];
   end

   // Receive pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else if (clk_en) begin
         rx_meta <= rxd_pin;
         rx_sync <= rx_meta;
      end
   end

   // Receiver: start is confirmed at half a bit, then one sample per bit
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_st    <= UBS_RX_IDLE;
         rx_os    <= 4'h0;
         rx_idx   <= 3'h0;
         rx_shift <= 8'h00;
         rx_par   <= 1'b0;
      end else if (clk_en) begin
         if (!async_mode_reg.rx_en) rx_st <= UBS_RX_IDLE; // Abort leaves buffer as is
         else if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            case (rx_st)
               UBS_RX_IDLE: begin
                  rx_os <= 4'h0;
                  if (!rx_sync) rx_st <= UBS_RX_START;
               end
               UBS_RX_START: begin
                  if (rx_os == `UBS_OS_MID) begin
                     rx_os  <= 4'h0;
                     rx_idx <= 3'h0;
                     rx_st  <= rx_sync ? UBS_RX_IDLE : UBS_RX_DATA; // Glitch filter
                  end
               end
               UBS_RX_DATA: begin
                  if (rx_os == `UBS_OS_LAST) begin
                     rx_shift[rx_idx] <= rx_sync;
                     rx_idx <= rx_idx + 3'h1;
                     if (rx_idx == last_idx)
                        rx_st <= (async_mode_reg.parity_sel == UBS_PAR_NONE) ?
                                 UBS_RX_STOP : UBS_RX_PAR;
                  end
               end
               UBS_RX_PAR: begin
                  if (rx_os == `UBS_OS_LAST) begin
                     rx_par <= rx_sync;
                     rx_st  <= UBS_RX_STOP;
                  end
               end
               UBS_RX_STOP: begin
                  if (rx_os == `UBS_OS_LAST) rx_st <= UBS_RX_IDLE;
               end
               default: rx_st <= UBS_RX_IDLE;
            endcase
         end
      end
   end

   assign frame_done = clk_en && async_mode_reg.rx_en && os_tick
                       && (rx_st == UBS_RX_STOP) && (rx_os == `UBS_OS_LAST);

   // Error causes of the frame now completing
   always_comb begin
      done_err = '0;
      case (async_mode_reg.parity_sel)
         UBS_PAR_EVEN: done_err.parity_error_flag =
            ubs_ones_odd(rx_shift, async_mode_reg.char_length_bit) ^ rx_par;
         UBS_PAR_ODD: done_err.parity_error_flag =
            !(ubs_ones_odd(rx_shift, async_mode_reg.char_length_bit) ^ rx_par);
         default: done_err.parity_error_flag = 1'b0;
      endcase
      done_err.framing_error_flag = !rx_sync;
      done_err.overrun_flag       = rx_full && !rxb_read;
   end

   // Buffer and flags; a completing frame wins over a same-cycle read
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         receive_buffer <= `UBS_RXB_RST;
         rx_full        <= 1'b0;
         err            <= '0;
      end else if (frame_done) begin
         receive_buffer <= async_mode_reg.char_length_bit ?
                           rx_shift : {1'b0, rx_shift[6:0]};
         rx_full        <= 1'b1;
         err            <= done_err;
      end else if (rxb_read) begin
         rx_full <= 1'b0;
         err     <= '0;
      end
   end

   // Parity bit to send
   always_comb begin
      case (async_mode_reg.parity_sel)
         UBS_PAR_EVEN: par_bit = ubs_ones_odd(tx_char, 1'b1);
         UBS_PAR_ODD:  par_bit = !ubs_ones_odd(tx_char, 1'b1);
         default:      par_bit = 1'b0;
      endcase
   end

   // Transmitter; writes while busy are dropped, so poll the state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_st      <= UBS_TX_IDLE;
         tx_os      <= 4'h0;
         tx_idx     <= 3'h0;
         tx_char    <= 8'h00;
         tx_stop2nd <= 1'b0;
         txd        <= 1'b1;
      end else if (clk_en) begin
         if (!async_mode_reg.tx_en) begin
            tx_st <= UBS_TX_IDLE;
            txd   <= 1'b1;
         end else if (tx_go) begin
            tx_char    <= async_mode_reg.char_length_bit ?
                          wr_data : {1'b0, wr_data[6:0]};
            tx_st      <= UBS_TX_START;
            tx_os      <= 4'h0;
            tx_idx     <= 3'h0;
            tx_stop2nd <= 1'b0;
            txd        <= 1'b0;
         end else if (os_tick && tx_st != UBS_TX_IDLE) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `UBS_OS_LAST) begin
               case (tx_st)
                  UBS_TX_START: begin
                     tx_st <= UBS_TX_DATA;
                     txd   <= tx_char[0];
                  end
                  UBS_TX_DATA: begin
                     tx_idx <= next_tx_idx;
                     if (tx_idx != last_idx) txd <= tx_char[next_tx_idx];
                     else if (async_mode_reg.parity_sel == UBS_PAR_NONE) begin
                        tx_st <= UBS_TX_STOP;
                        txd   <= 1'b1;
                     end else begin
                        tx_st <= UBS_TX_PAR;
                        txd   <= par_bit;
                     end
                  end
                  UBS_TX_PAR: begin
                     tx_st <= UBS_TX_STOP;
                     txd   <= 1'b1;
                  end
                  UBS_TX_STOP: begin
                     if (async_mode_reg.stop_length_bit && !tx_stop2nd) tx_stop2nd <= 1'b1;
                     else tx_st <= UBS_TX_IDLE;
                  end
                  default: tx_st <= UBS_TX_IDLE;
               endcase
            end
         end
      end
   end

   // Status byte, upper bits zero
   always_comb begin
      stat_byte = 8'h00;
      stat_byte[`UBS_PE_BIT]  = err.parity_error_flag;
      stat_byte[`UBS_FE_BIT]  = err.framing_error_flag;
      stat_byte[`UBS_OVE_BIT] = err.overrun_flag;
   end

   // Read port: data registered, unmapped and write-only addresses read zero
   always_ff @(posedge sys_clk) begin
      if (srst) rd_data <= 8'h00;
      else if (clk_en) begin
         if (!rd_stb) rd_data <= 8'h00;
         else if (addr == `UBS_ADDR_MODE) rd_data <= async_mode_reg;
         else if (addr == `UBS_ADDR_STAT) rd_data <= stat_byte;
         else if (addr == `UBS_ADDR_BAUD) rd_data <= {baud_sel, 4'h0};
         else if (addr == `UBS_ADDR_RXB) rd_data <= receive_buffer;
         else if (addr == `UBS_ADDR_STATE)
            rd_data <= {6'h00, rx_full, tx_st != UBS_TX_IDLE};
         else rd_data <= 8'h00;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_stat_read;
      clk_en && rd_stb && addr == `UBS_ADDR_STAT |=>
         rd_data == {5'h00, $past(err.parity_error_flag), $past(err.framing_error_flag),
                     $past(err.overrun_flag)};
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   property p_pe_even;
      frame_done && async_mode_reg.parity_sel == UBS_PAR_EVEN && rx_par ^
         ubs_ones_odd(rx_shift, async_mode_reg.char_length_bit) |=> err.parity_error_flag;
   endproperty
   a_pe_even: assert property (p_pe_even) else $error("even parity error missed");

   property p_pe_odd;
      frame_done && async_mode_reg.parity_sel == UBS_PAR_ODD && rx_par ==
         ubs_ones_odd(rx_shift, async_mode_reg.char_length_bit) |=> err.parity_error_flag;
   endproperty
   a_pe_odd: assert property (p_pe_odd) else $error("odd parity error missed");

   property p_no_pe;
      frame_done && !async_mode_reg.parity_sel[1] |=> !err.parity_error_flag;
   endproperty
   a_no_pe: assert property (p_no_pe) else $error("parity error without check");

   property p_fe;
      frame_done && !rx_sync |=> err.framing_error_flag && rx_full;
   endproperty
   a_fe: assert property (p_fe) else $error("framing error missed");

   property p_ove;
      frame_done && rx_full && !rxb_read |=> err.overrun_flag;
   endproperty
   a_ove: assert property (p_ove) else $error("overrun missed");

   property p_bit7;
      frame_done && !async_mode_reg.char_length_bit |=> !receive_buffer[7];
   endproperty
   a_bit7: assert property (p_bit7) else $error("bit 7 not zero");

   property p_clear;
      rxb_read && !frame_done |=> err == '0 && !rx_full;
   endproperty
   a_clear: assert property (p_clear) else $error("flags not cleared by read");

   property p_baud_low;
      clk_en && rd_stb && addr == `UBS_ADDR_BAUD |=> rd_data == {$past(baud_sel), 4'h0};
   endproperty
   a_baud_low: assert property (p_baud_low) else $error("baud select read wrong");

   property p_tx_start;
      tx_go |=> !txd && tx_st == UBS_TX_START;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("start bit not sent");

   c_frame:   cover property (frame_done);
   c_overrun: cover property (frame_done && rx_full && !rxb_read);
   c_parerr:  cover property (frame_done && done_err.parity_error_flag);
   c_txdone:  cover property (tx_st == UBS_TX_STOP ##1 tx_st == UBS_TX_IDLE);
endmodule : ubs_top
`default_nettype wire

/* File: test/ubs_remote.sv */
// Remote serial device model: sends frames into the block and samples frames from it
`timescale 1ns/1ps
`default_nettype none
module ubs_remote (
   input  wire logic sys_clk,  // System clock, used as bit timer
   input  wire logic txd,      // Line from the block
   output logic      rxd       // Line into the block, idles high
);
   int bit_cyc = 32;  // Bit length in system clocks, set by the bench

   initial rxd = 1'b1;

   // Send one frame; a bad stop is low only three quarters of a bit so no false start follows
   task automatic send(input logic [7:0] d, input int nb, input logic has_par,
                       input logic par, input logic stop);
      rxd <= 1'b0;
      repeat (bit_cyc) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         rxd <= d[i];
         repeat (bit_cyc) @(posedge sys_clk);
      end
      if (has_par) begin
         rxd <= par;
         repeat (bit_cyc) @(posedge sys_clk);
      end
      rxd <= stop;
      repeat (stop ? bit_cyc : bit_cyc * 3 / 4) @(posedge sys_clk);
      // Line is already high after a good stop; a back to back start may follow at once
      if (!stop) begin
         rxd <= 1'b1;
         repeat (bit_cyc) @(posedge sys_clk);
      end
   endtask : send

   // Sample a frame in the middle of each bit, LSB first
   task automatic recv(input int nb, input logic has_par, output logic [7:0] d,
                       output logic par, output logic stop);
      d = 8'h00;
      par = 1'b0;
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (bit_cyc) @(posedge sys_clk);
         d[i] = txd;
      end
      if (has_par) begin
         repeat (bit_cyc) @(posedge sys_clk);
         par = txd;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      stop = txd;
   endtask : recv
endmodule : ubs_remote
`default_nettype wire

/* File: test/ubs_top_tb_top.sv */
// Self-checking bench for the serial block: registers, transmit, receive, errors, baud source
`timescale 1ns/1ps
`default_nettype none
`include "ubs_params.svh"
module ubs_top_tb_top
   import ubs_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        srst    = 1'b1;
   logic [15:0] addr    = 16'h0000;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_stb  = 1'b0;
   logic        rd_stb  = 1'b0;
   logic [7:0]  rd_data;
   logic        ext_pin = 1'b0;
   logic        ext_on  = 1'b0;
   logic [1:0]  ext_cnt = 2'h0;
   logic        clk_en  = 1'b1;
   logic        rxd_pin;
   logic        txd;
   int          failures = 0;
   int          checks   = 0;

   always #12.5 sys_clk = ~sys_clk;
   // External source: 8 system clocks a period, toggles only while selected
   always @(posedge sys_clk) begin
      if (ext_on) ext_cnt <= ext_cnt + 2'h1;
      if (ext_on && ext_cnt == 2'h3) ext_pin <= ~ext_pin;
   end

   ubs_top u_dut (
      .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rxd_pin(rxd_pin),
      .external_baud_clock_pin(ext_pin), .txd(txd));
   ubs_remote u_rem (.sys_clk(sys_clk), .txd(txd), .rxd(rxd_pin));

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk(n, rd_data, exp);
   endtask : rd_chk

   function automatic logic [7:0] md(input ubs_par_t p, input logic c8, input logic s2);
      return {2'b11, p, c8, s2, 2'b00};
   endfunction : md

   // Parity bit that makes the count of ones match the type
   function automatic logic pbit(input ubs_par_t p, input logic [7:0] d);
      return (p == UBS_PAR_EVEN) ? ^d : (p == UBS_PAR_ODD) ? ~^d : 1'b0;
   endfunction : pbit

   task automatic rx_case(input ubs_par_t p, input logic c8, input logic [7:0] d,
                          input logic flip, input logic stop, input logic [7:0] exp_st);
      logic [7:0] dm;
      dm = c8 ? d : {1'b0, d[6:0]};
      wr(`UBS_ADDR_MODE, md(p, c8, 1'b0));
      u_rem.send(d, c8 ? 8 : 7, p != UBS_PAR_NONE, pbit(p, dm) ^ flip, stop);
      repeat (8) @(posedge sys_clk);
      rd_chk("status", `UBS_ADDR_STAT, exp_st);
      rd_chk("rx data", `UBS_ADDR_RXB, dm);
      rd_chk("status after read", `UBS_ADDR_STAT, 8'h00);
   endtask : rx_case

   task automatic t_regs();
      rd_chk("status reset", `UBS_ADDR_STAT, 8'h00);
      rd_chk("baud reset", `UBS_ADDR_BAUD, 8'h00);
      wr(`UBS_ADDR_BAUD, 8'h3C);
      rd_chk("baud low nibble", `UBS_ADDR_BAUD, 8'h30);
      // Strobes are ignored while the clock enable is low
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(`UBS_ADDR_BAUD, 8'h50);
      clk_en <= 1'b1;
      rd_chk("frozen write", `UBS_ADDR_BAUD, 8'h30);
      wr(`UBS_ADDR_STAT, 8'hFF);
      rd_chk("status read only", `UBS_ADDR_STAT, 8'h00);
      rd_chk("unmapped", 16'hFF7F, 8'h00);
      wr(`UBS_ADDR_MODE, 8'hFF);
      rd_chk("mode fields", `UBS_ADDR_MODE, 8'hFC);
      // Divide by two is fine at 40 MHz; the low-clock limit does not apply here
      wr(`UBS_ADDR_BAUD, 8'h00);
      wr(`UBS_ADDR_MODE, 8'h00);
      $display("test regs done");
   endtask : t_regs

   // Every parity type in both lengths; stop length seen through the busy bit
   task automatic t_tx();
      logic [7:0] d;
      logic [7:0] dm;
      logic       pb;
      logic       sb;
      ubs_par_t   p;
      logic       c8;
      logic       s2;
      for (int k = 0; k < 8; k++) begin
         p = ubs_par_t'(k[1:0]);
         c8 = k[2];
         s2 = k[2] ^ k[0];
         dm = c8 ? 8'hB5 : 8'h35;
         wr(`UBS_ADDR_MODE, md(p, c8, s2));
         wr(`UBS_ADDR_TXB, 8'hB5);
         u_rem.recv(c8 ? 8 : 7, p != UBS_PAR_NONE, d, pb, sb);
         chk("tx data", d, dm);
         chk("tx parity", {7'h00, pb}, {7'h00, pbit(p, dm)});
         chk("tx stop", {7'h00, sb}, 8'h01);
         repeat (u_rem.bit_cyc * 3 / 4) @(posedge sys_clk);
         rd_chk("tx busy", `UBS_ADDR_STATE, {7'h00, s2});
         repeat (u_rem.bit_cyc * 2) @(posedge sys_clk);
      end
      $display("test tx done");
   endtask : t_tx

   task automatic t_rx();
      rx_case(UBS_PAR_EVEN, 1'b1, 8'hB5, 1'b0, 1'b1, 8'h00);
      rx_case(UBS_PAR_EVEN, 1'b1, 8'hB5, 1'b1, 1'b1, 8'h04);
      rx_case(UBS_PAR_ODD, 1'b0, 8'hB5, 1'b1, 1'b1, 8'h04);
      rx_case(UBS_PAR_ODD, 1'b0, 8'h4C, 1'b0, 1'b1, 8'h00);
      rx_case(UBS_PAR_ZERO, 1'b1, 8'hB5, 1'b1, 1'b1, 8'h00);
      rx_case(UBS_PAR_NONE, 1'b0, 8'hFF, 1'b0, 1'b1, 8'h00);
      rx_case(UBS_PAR_NONE, 1'b1, 8'h5A, 1'b0, 1'b0, 8'h02);
      $display("test rx done");
   endtask : t_rx

   // Frames back to back with one stop while two are set, buffer left unread
   task automatic t_ovr();
      wr(`UBS_ADDR_MODE, md(UBS_PAR_EVEN, 1'b1, 1'b1));
      u_rem.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
      u_rem.send(8'h22, 8, 1'b1, 1'b0, 1'b1);
      repeat (8) @(posedge sys_clk);
      rd_chk("overrun", `UBS_ADDR_STAT, 8'h01);
      u_rem.send(8'h33, 8, 1'b1, 1'b1, 1'b0);
      repeat (8) @(posedge sys_clk);
      rd_chk("all flags", `UBS_ADDR_STAT, 8'h07);
      u_rem.send(8'h44, 8, 1'b1, 1'b0, 1'b1);
      repeat (8) @(posedge sys_clk);
      rd_chk("next frame", `UBS_ADDR_STAT, 8'h01);
      rd_chk("rx data", `UBS_ADDR_RXB, 8'h44);
      rd_chk("cleared", `UBS_ADDR_STAT, 8'h00);
      $display("test overrun done");
   endtask : t_ovr

   // Select writes only while the line is idle, since a write mid-frame corrupts it
   task automatic t_baud();
      for (int k = 1; k < 3; k++) begin
         wr(`UBS_ADDR_BAUD, {k[3:0], 4'h0});
         u_rem.bit_cyc = 16 << (k + 1);
         rx_case(UBS_PAR_ODD, 1'b1, 8'hA7, 1'b0, 1'b1, 8'h00);
      end
      ext_on = 1'b1;
      wr(`UBS_ADDR_BAUD, 8'h80);
      u_rem.bit_cyc = 128;
      rx_case(UBS_PAR_EVEN, 1'b1, 8'hC3, 1'b0, 1'b1, 8'h00);
      wr(`UBS_ADDR_BAUD, 8'h00);
      ext_on = 1'b0;
      u_rem.bit_cyc = 32;
      $display("test baud done");
   endtask : t_baud

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Tests need about 11000 cycles; the limit leaves ample margin
   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      $display("watchdog expired");
      finish_test();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_tx();
      t_rx();
      t_ovr();
      t_baud();
      finish_test();
   end
endmodule : ubs_top_tb_top
`default_nettype wire
